//--- logic/io_port_defines.vh
`ifndef IO_PORT_DEFINES_VH
`define IO_PORT_DEFINES_VH

`define ADDR_PORT0_LATCH 8'h80
`define ADDR_PORT1_LATCH 8'h90
`define ADDR_PORT2_LATCH 8'hA0
`define ADDR_PORT0_MODE_A 8'h84
`define ADDR_PORT0_MODE_B 8'h85
`define ADDR_PORT1_MODE_A 8'h91
`define ADDR_PORT1_MODE_B 8'h92
`define ADDR_PORT2_MODE_SHARED 8'hA4
`define ADDR_PORT2_MODE_B 8'hA5

`define RST_MODE_REG 8'h00
`define RST_SHARED_REG 8'h00
`define LATCH_HIGH 8'hFF
`define LATCH_LOW 8'h00

`define MODE_QUASI 2'b00
`define MODE_PUSH_PULL 2'b01
`define MODE_INPUT_ONLY 2'b10
`define MODE_OPEN_DRAIN 2'b11

`define BIT_THIRD_PORT_SCHMITT 7
`define BIT_SECOND_PORT_SCHMITT 6
`define BIT_FIRST_PORT_SCHMITT 5
`define BIT_RC_CLOCK_OUT 4
`define BIT_TIMER_B_TOGGLE 3
`define BIT_TIMER_A_TOGGLE 2

`define PIN_FIXED_OD_LO 10
`define PIN_FIXED_OD_HI 11
`define PIN_FIXED_INPUT 13
`define PIN_CRYSTAL_OUT 16
`define PIN_CRYSTAL_IN 17
`define PIN_TIMER_B_TOGGLE 7
`define STRONG_PULSE_CLKS 2

`endif

//--- logic/io_port.v
`timescale 1ns/1ps
`include "io_port_defines.vh"

module io_port (
	input wire clk,
	input wire nrst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [23:0] pad_in,
	output reg [23:0] pad_out,
	output reg [23:0] pad_oe,
	output reg [23:0] weak_pu_en,
	output reg [23:0] very_weak_pu_en,
	output reg [23:0] schmitt_en,
	output reg [23:0] input_en,
	input wire port_reset_level_select,
	input wire crystal_osc_selected,
	input wire rc_osc_selected,
	input wire internal_reset_selected,
	input wire timer_a_overflow,
	input wire timer_b_overflow
);

	reg [23:0] pin_meta_q;
	reg [23:0] pin_sync_q;
	reg [3:0] cfg_meta_q;
	reg [3:0] cfg_sync_q;
	reg [1:0] init_q;
	reg [7:0] latch0_q;
	reg [7:0] latch1_q;
	reg [7:0] latch2_q;
	reg [7:0] mode0_a_q;
	reg [7:0] mode0_b_q;
	reg [7:0] mode1_a_q;
	reg [7:0] mode1_b_q;
	reg [7:0] port2_mode_and_misc_enable_q;
	reg [7:0] mode2_b_q;
	reg timer_a_tog_q;
	reg timer_b_tog_q;
	reg clk_div_q;
	reg [7:0] rdata_d;
	reg [7:0] latch0_d;
	reg [7:0] latch1_d;
	reg [7:0] latch2_d;
	reg [7:0] mode0_a_d;
	reg [7:0] mode0_b_d;
	reg [7:0] mode1_a_d;
	reg [7:0] mode1_b_d;
	reg [7:0] port2_mode_and_misc_enable_d;
	reg [7:0] mode2_b_d;
	reg timer_a_tog_d;
	reg timer_b_tog_d;
	reg clk_div_d;

	wire reset_high_sync;
	wire xtal_sel;
	wire rc_sel;
	wire int_rst_sel;
	wire init_load;
	wire [23:0] latch_all;
	wire [23:0] mode_a_all;
	wire [23:0] mode_b_all;
	wire [23:0] pin_read;
	wire [2:0] port_schmitt;
	wire clk_out_on;
	wire tog_a_on;
	wire tog_b_on;

	// Pads and straps come from outside this clock domain.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_meta_q <= 24'h00_0000;
			pin_sync_q <= 24'h00_0000;
			cfg_meta_q <= 4'h0;
			cfg_sync_q <= 4'h0;
		end else begin
			pin_meta_q <= pad_in;
			pin_sync_q <= pin_meta_q;
			cfg_meta_q <= {internal_reset_selected, rc_osc_selected, crystal_osc_selected, port_reset_level_select};
			cfg_sync_q <= cfg_meta_q;
		end
	end

	assign reset_high_sync = cfg_sync_q[0];
	assign xtal_sel = cfg_sync_q[1];
	assign rc_sel = cfg_sync_q[2];
	assign int_rst_sel = cfg_sync_q[3];

	// Latch reset level is taken once the strap has passed the synchroniser.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			init_q <= 2'b00;
		end else if (init_q != 2'b11) begin
			init_q <= init_q + 2'b01;
		end
	end

	assign init_load = (init_q == 2'b10);

	// Enables decoded from the shared mode register.
	assign clk_out_on = port2_mode_and_misc_enable_q[`BIT_RC_CLOCK_OUT] & rc_sel;
	assign tog_a_on = port2_mode_and_misc_enable_q[`BIT_TIMER_A_TOGGLE];
	assign tog_b_on = port2_mode_and_misc_enable_q[`BIT_TIMER_B_TOGGLE];

	// Next values of the port latches and mode registers.
	always @* begin
		latch0_d = latch0_q;
		latch1_d = latch1_q;
		latch2_d = latch2_q;
		mode0_a_d = mode0_a_q;
		mode0_b_d = mode0_b_q;
		mode1_a_d = mode1_a_q;
		mode1_b_d = mode1_b_q;
		mode2_b_d = mode2_b_q;
		port2_mode_and_misc_enable_d = port2_mode_and_misc_enable_q;
		if (init_load) begin
			latch0_d = reset_high_sync ? `LATCH_HIGH : `LATCH_LOW;
			latch1_d = reset_high_sync ? `LATCH_HIGH : `LATCH_LOW;
			latch2_d = reset_high_sync ? `LATCH_HIGH : `LATCH_LOW;
		end else if (reg_wr) begin
			case (reg_addr)
				`ADDR_PORT0_LATCH: begin
					latch0_d = reg_wdata;
				end
				`ADDR_PORT1_LATCH: begin
					latch1_d = reg_wdata;
				end
				`ADDR_PORT2_LATCH: begin
					latch2_d = reg_wdata;
				end
				`ADDR_PORT0_MODE_A: begin
					mode0_a_d = reg_wdata;
				end
				`ADDR_PORT0_MODE_B: begin
					mode0_b_d = reg_wdata;
				end
				`ADDR_PORT1_MODE_A: begin
					mode1_a_d = reg_wdata;
				end
				`ADDR_PORT1_MODE_B: begin
					mode1_b_d = reg_wdata;
				end
				`ADDR_PORT2_MODE_SHARED: begin
					port2_mode_and_misc_enable_d = reg_wdata;
				end
				`ADDR_PORT2_MODE_B: begin
					mode2_b_d = reg_wdata;
				end
				default: begin
					latch0_d = latch0_q;
				end
			endcase
		end
	end

	// Port latches and mode registers.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			latch0_q <= `LATCH_LOW;
			latch1_q <= `LATCH_LOW;
			latch2_q <= `LATCH_LOW;
			mode0_a_q <= `RST_MODE_REG;
			mode0_b_q <= `RST_MODE_REG;
			mode1_a_q <= `RST_MODE_REG;
			mode1_b_q <= `RST_MODE_REG;
			mode2_b_q <= `RST_MODE_REG;
			port2_mode_and_misc_enable_q <= `RST_SHARED_REG;
		end else begin
			latch0_q <= latch0_d;
			latch1_q <= latch1_d;
			latch2_q <= latch2_d;
			mode0_a_q <= mode0_a_d;
			mode0_b_q <= mode0_b_d;
			mode1_a_q <= mode1_a_d;
			mode1_b_q <= mode1_b_d;
			mode2_b_q <= mode2_b_d;
			port2_mode_and_misc_enable_q <= port2_mode_and_misc_enable_d;
		end
	end

	// Timer toggle outputs and the divided clock output.
	always @* begin
		timer_a_tog_d = timer_a_tog_q;
		timer_b_tog_d = timer_b_tog_q;
		clk_div_d = 1'b0;
		if (tog_a_on && timer_a_overflow) begin
			timer_a_tog_d = ~timer_a_tog_q;
		end
		if (tog_b_on && timer_b_overflow) begin
			timer_b_tog_d = ~timer_b_tog_q;
		end
		if (clk_out_on) begin
			clk_div_d = ~clk_div_q;
		end
	end

	// Toggle and clock flops; the divided clock rests low while disabled.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timer_a_tog_q <= 1'b0;
			timer_b_tog_q <= 1'b0;
			clk_div_q <= 1'b0;
		end else begin
			timer_a_tog_q <= timer_a_tog_d;
			timer_b_tog_q <= timer_b_tog_d;
			clk_div_q <= clk_div_d;
		end
	end

	// Pins are numbered port times eight plus bit.
	assign latch_all = {latch2_q, latch1_q, latch0_q};
	assign mode_a_all = {6'b00_0000, port2_mode_and_misc_enable_q[1:0], mode1_a_q, mode0_a_q};
	assign mode_b_all = {6'b00_0000, mode2_b_q[1:0], mode1_b_q, mode0_b_q};
	assign port_schmitt = {port2_mode_and_misc_enable_q[`BIT_THIRD_PORT_SCHMITT],
		port2_mode_and_misc_enable_q[`BIT_SECOND_PORT_SCHMITT],
		port2_mode_and_misc_enable_q[`BIT_FIRST_PORT_SCHMITT]};

	// Per-pin mode selection and driver control.
	genvar i;
	generate
		for (i = 0; i < 24; i = i + 1) begin : pin
			wire fixed_od;
			wire fixed_in;
			wire xtal_pin;
			wire clk_pin;
			wire no_pin;
			wire [1:0] cfg;
			reg [1:0] mode;
			wire lvl;
			wire quasi;
			wire rise;
			reg prev_q;
			reg pulse_q;
			reg pd;
			reg su;
			reg wu;
			reg vu;

			assign fixed_od = (i == `PIN_FIXED_OD_LO) || (i == `PIN_FIXED_OD_HI);
			assign fixed_in = (i == `PIN_FIXED_INPUT);
			assign xtal_pin = ((i == `PIN_CRYSTAL_OUT) || (i == `PIN_CRYSTAL_IN)) && xtal_sel;
			assign clk_pin = (i == `PIN_CRYSTAL_OUT) && clk_out_on;
			assign no_pin = xtal_pin || (fixed_in && !int_rst_sel);
			assign cfg = {mode_a_all[i], mode_b_all[i]};

			// Fixed functions override the configured mode.
			always @* begin
				if (xtal_pin) begin
					mode = `MODE_INPUT_ONLY;
				end else if (clk_pin) begin
					mode = `MODE_PUSH_PULL;
				end else if (fixed_od) begin
					mode = `MODE_OPEN_DRAIN;
				end else if (fixed_in) begin
					mode = `MODE_INPUT_ONLY;
				end else if (i >= 18) begin
					mode = `MODE_INPUT_ONLY;
				end else begin
					mode = cfg;
				end
			end

			assign lvl = clk_pin ? clk_div_q :
				((i == `PIN_FIXED_OD_LO) && tog_a_on) ? timer_a_tog_q :
				((i == `PIN_TIMER_B_TOGGLE) && tog_b_on) ? timer_b_tog_q :
				latch_all[i];
			assign quasi = (mode == `MODE_QUASI);
			assign rise = lvl && !prev_q;

			always @* begin
				pd = 1'b0;
				su = 1'b0;
				wu = 1'b0;
				vu = 1'b0;
				case (mode)
					`MODE_QUASI: begin
						pd = !lvl;
						vu = lvl;
						wu = lvl && pin_sync_q[i];
						su = rise || pulse_q;
					end
					`MODE_PUSH_PULL: begin
						pd = !lvl;
						su = lvl;
					end
					`MODE_OPEN_DRAIN: begin
						pd = !lvl;
					end
					default: begin
						pd = 1'b0;
					end
				endcase
			end

			// Drivers are registered so pads follow the pin state one edge later.
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					prev_q <= 1'b0;
					pulse_q <= 1'b0;
					pad_out[i] <= 1'b0;
					pad_oe[i] <= 1'b0;
					weak_pu_en[i] <= 1'b0;
					very_weak_pu_en[i] <= 1'b0;
					schmitt_en[i] <= 1'b0;
					input_en[i] <= 1'b0;
				end else begin
					prev_q <= lvl;
					pulse_q <= rise && quasi;
					pad_out[i] <= su;
					pad_oe[i] <= su || pd;
					weak_pu_en[i] <= wu;
					very_weak_pu_en[i] <= vu;
					schmitt_en[i] <= port_schmitt[i / 8] || fixed_od || (i == `PIN_FIXED_INPUT);
					input_en[i] <= !no_pin && (i < 18);
				end
			end

			assign pin_read[i] = pin_sync_q[i] && !no_pin && (i < 18);
		end
	endgenerate

	// Read data stands in the cycle after the read strobe only.
	always @* begin
		rdata_d = 8'h00;
		case (reg_addr)
			`ADDR_PORT0_LATCH: begin
				rdata_d = pin_read[7:0];
			end
			`ADDR_PORT1_LATCH: begin
				rdata_d = pin_read[15:8];
			end
			`ADDR_PORT2_LATCH: begin
				rdata_d = pin_read[23:16];
			end
			`ADDR_PORT0_MODE_A: begin
				rdata_d = mode0_a_q;
			end
			`ADDR_PORT0_MODE_B: begin
				rdata_d = mode0_b_q;
			end
			`ADDR_PORT1_MODE_A: begin
				rdata_d = mode1_a_q;
			end
			`ADDR_PORT1_MODE_B: begin
				rdata_d = mode1_b_q;
			end
			`ADDR_PORT2_MODE_SHARED: begin
				rdata_d = port2_mode_and_misc_enable_q;
			end
			`ADDR_PORT2_MODE_B: begin
				rdata_d = mode2_b_q;
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// Read data is cleared when no read is taken.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule // io_port

//--- tb/io_port_checker.sv
`timescale 1ns/1ps
module io_port_checker (
	input wire clk,
	input wire nrst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire [23:0] pad_in,
	input wire [23:0] pad_out,
	input wire [23:0] pad_oe,
	input wire [23:0] weak_pu_en,
	input wire [23:0] very_weak_pu_en,
	input wire [23:0] schmitt_en,
	input wire [23:0] input_en,
	input wire crystal_osc_selected,
	input wire internal_reset_selected,
	input wire timer_a_overflow
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	reg tgl_a_q;
	// Shadow of the timer A toggle enable, so its pin is only judged while enabled.
	always @(posedge clk or negedge nrst)
		if (!nrst)
			tgl_a_q <= 1'b0;
		else if (reg_wr && reg_addr == 8'ha4)
			tgl_a_q <= reg_wdata[2];
	sequence strong_start;
		$rose(pad_oe[0] && pad_out[0]) && very_weak_pu_en[0];
	endsequence
	sequence strong_pulse;
		(pad_oe[0] && pad_out[0]) [*2] ##1 !pad_oe[0];
	endsequence
	sequence pin_held_low;
		$fell(pad_in[0]) ##1 !pad_in[0] [*2];
	endsequence
	a_strong_pulse: assert property (strong_start |-> strong_pulse)
		else $error("strong pulse length wrong");
	a_vw_no_sink: assert property ((very_weak_pu_en & pad_oe & ~pad_out) == 24'h00_0000)
		else $error("pull-up beside pulldown");
	a_weak_needs_vw: assert property ((weak_pu_en & ~very_weak_pu_en) == 24'h00_0000)
		else $error("weak pull-up without latch one");
	a_weak_drop: assert property (pin_held_low |=> !weak_pu_en[0])
		else $error("weak pull-up kept on low pin");
	a_fixed_pins: assert property (((very_weak_pu_en | weak_pu_en | pad_out & pad_oe) & 24'h00_0c00) == 24'h00_0000
		&& !pad_oe[13])
		else $error("fixed pin sources current");
	a_absent_float: assert property (pad_oe[23:18] == 6'h00 && input_en[23:18] == 6'h00)
		else $error("absent pin active");
	a_xtal_off: assert property (crystal_osc_selected [*5] |-> pad_oe[17:16] == 2'h0 && input_en[17:16] == 2'h0)
		else $error("crystal pin active");
	a_reset_pin_gate: assert property (!internal_reset_selected [*5] |-> !input_en[13])
		else $error("fixed input enabled");
	a_fixed_schmitt: assert property ($past(nrst, 3) |-> (schmitt_en & 24'h00_2c00) == 24'h00_2c00)
		else $error("fixed pin not Schmitt");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_toggle_a: assert property (tgl_a_q && timer_a_overflow |-> ##[2:3] $changed(pad_oe[10]))
		else $error("timer A pin not toggled");
endmodule // io_port_checker

//--- tb/pin_world.sv
`timescale 1ns/1ps
module pin_world (
	input wire clk,
	input wire [23:0] pad_out,
	input wire [23:0] pad_oe,
	input wire [23:0] weak_pu_en,
	input wire [23:0] very_weak_pu_en,
	input wire [23:0] ext_low,
	output wire [23:0] pad_in
);
	reg [23:0] noise_q = 24'h00_0000;
	wire [23:0] pu = weak_pu_en | very_weak_pu_en;
	// Driven pins win, then an external sink; a pin with no pull-up floats and wanders.
	always @(posedge clk)
		noise_q <= ~noise_q;
	assign pad_in = pad_oe & pad_out | ~pad_oe & ~ext_low & (pu | noise_q);
endmodule // pin_world

//--- tb/io_port_tb.sv
`timescale 1ns/1ps
module io_port_tb;
	reg clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, strap = 1'b1;
	reg xtal = 1'b0, rc = 1'b0, irst = 1'b0, ovf_a = 1'b0, ovf_b = 1'b0;
	reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	reg [23:0] ext_low = 24'h00_0000;
	wire [7:0] reg_rdata;
	wire [23:0] pad_in, pad_out, pad_oe, weak_pu_en, very_weak_pu_en, schmitt_en, input_en;
	int error_cnt = 0, num_checks = 0, cycles = 0, i, m, k;
	reg [7:0] mem [0:255];
	reg [7:0] adr [0:6] = '{8'h84, 8'h85, 8'h91, 8'h92, 8'ha4, 8'ha5, 8'h33};
	logic [3:0] e;
	logic b;
	always #25 clk = ~clk;
	io_port dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pad_in, .pad_out,
		.pad_oe, .weak_pu_en, .very_weak_pu_en, .schmitt_en, .input_en, .port_reset_level_select(strap),
		.crystal_osc_selected(xtal), .rc_osc_selected(rc), .internal_reset_selected(irst),
		.timer_a_overflow(ovf_a), .timer_b_overflow(ovf_b));
	pin_world far_side (.clk, .pad_out, .pad_oe, .weak_pu_en, .very_weak_pu_en, .ext_low, .pad_in);
	task automatic chk(input [23:0] seen, input [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input [7:0] a, input [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		mem[a] = v;
	endtask
	task automatic rd(input [7:0] a, input [7:0] pins = 8'h00);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(24'(reg_rdata), 24'(a inside {8'h84, 8'h85, 8'h91, 8'h92, 8'ha4, 8'ha5} ? mem[a] : pins));
	endtask
	task conclude;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			conclude;
		end
	end
	initial begin
		i = $urandom(89);
		for (i = 0; i < 256; i++)
			mem[i] = 8'h00;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		wait_n(12);
		chk(24'({pad_oe[7:0], very_weak_pu_en[7:0], weak_pu_en[7:0]}), 24'h00_ffff);
		for (k = 0; k < 7; k++)
			rd(adr[k]);
		for (k = 0; k < 4; k++) begin
			m = $urandom;
			wr(8'h85, m[7:0]);
			wr(8'ha5, m[15:8]);
			wr(8'h33, m[23:16]);
			wr(8'ha4, m[31:24]);
			for (i = 0; i < 7; i++)
				rd(adr[i]);
		end
		wr(8'h85, 8'h00);
		wr(8'ha5, 8'h00);
		wr(8'ha4, 8'h00);
		for (m = 0; m < 4; m++) begin
			wr(8'h80, 8'hfe);
			wr(8'h84, {7'h00, m[1]});
			wr(8'h85, {7'h00, m[0]});
			for (i = 0; i < 2; i++) begin
				wr(8'h80, {7'h7f, i[0]});
				wait_n(8);
				e = {m != 2 && (i == 0 || m == 1), m == 1 && i == 1, m == 0 && i == 1, m == 0 && i == 1};
				chk(24'({pad_oe[0], pad_out[0], very_weak_pu_en[0], weak_pu_en[0]}), 24'(e));
			end
		end
		wr(8'h84, 8'h00);
		wr(8'h85, 8'h00);
		@(posedge clk) ext_low[0] <= 1'b1;
		wait_n(6);
		chk(24'({very_weak_pu_en[0], weak_pu_en[0]}), 24'h00_0002);
		rd(8'h80, 8'hfe);
		@(posedge clk) ext_low[0] <= 1'b0;
		wr(8'ha4, 8'he0);
		wait_n(5);
		chk(24'(schmitt_en[17:0]), 24'h03_ffff);
		wr(8'ha4, 8'h00);
		wait_n(5);
		chk(24'(schmitt_en[17:0]), 24'h00_2c00);
		for (i = 0; i < 2; i++) begin
			wr(8'ha4, i ? 8'h08 : 8'h04);
			repeat (3) begin
				wait_n(4);
				b = i ? very_weak_pu_en[7] : pad_oe[10];
				@(posedge clk);
				ovf_a <= (i == 0);
				ovf_b <= (i == 1);
				@(posedge clk);
				ovf_a <= 1'b0;
				ovf_b <= 1'b0;
				wait_n(4);
				chk(24'(i ? very_weak_pu_en[7] : pad_oe[10]), 24'(!b));
			end
		end
		chk(24'(input_en[13]), 24'h00_0000);
		@(posedge clk) rc <= 1'b1;
		irst <= 1'b1;
		wr(8'ha4, 8'h10);
		wait_n(6);
		b = pad_out[16];
		wait_n(1);
		chk(24'({pad_oe[16], pad_out[16], input_en[13]}), 24'({2'h2 | !b, 1'b1}));
		@(posedge clk) xtal <= 1'b1;
		wait_n(6);
		chk(24'({pad_oe[17:16], input_en[17:16]}), 24'h00_0000);
		@(posedge clk) xtal <= 1'b0;
		nrst <= 1'b0;
		strap <= 1'b0;
		mem[8'ha4] = 8'h00;
		wait_n(2);
		@(posedge clk) nrst <= 1'b1;
		wait_n(12);
		chk(24'({pad_oe[7:0], very_weak_pu_en[7:0]}), 24'h00_ff00);
		rd(8'ha4);
		conclude;
	end
endmodule // io_port_tb
bind io_port io_port_checker chk_i (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pad_in,
	.pad_out, .pad_oe, .weak_pu_en, .very_weak_pu_en, .schmitt_en, .input_en, .crystal_osc_selected,
	.internal_reset_selected, .timer_a_overflow);
